// ==== common/dld_core_defines.vh ====
// constants for the dpll lock detect and phase accumulator core
// assumes a single 250 MHz sample clock
`ifndef DLD_CORE_DEFINES_VH
`define DLD_CORE_DEFINES_VH

// ==================================================================
// register map, byte wide
`define DLD_ADDR_PHASE_OFS_LO  16'h030d
`define DLD_ADDR_PHASE_OFS_HI  16'h030e
`define DLD_PHASE_OFS_RESET    16'h0000

// ==================================================================
// lock level counter
`define DLD_LEVEL_EMPTY        13'sh1800
`define DLD_LEVEL_FULL         13'sh0800
`define DLD_LEVEL_LOW_MARK     13'sh1c00
`define DLD_LEVEL_HIGH_MARK    13'sh0400
`define DLD_SUM_SAT_LO         14'sh3800
`define DLD_SUM_SAT_HI         14'sh0800

// ==================================================================
// loop modes
`define DLD_MODE_CLOSED        2'h0
`define DLD_MODE_FREERUN       2'h1
`define DLD_MODE_HOLDOVER      2'h2

// ==================================================================
// timing and arithmetic
`define DLD_CLK_PERIOD_PS      32'h00000fa0
`define DLD_MANT_FRAC_BITS     7'h10
`define DLD_PHASE_MSB          47
`define DLD_PHASE_LSB          32

`endif

// ==== logic/dld_core.v ====
// dpll digital core: loop filter, lock detectors, phase accumulator
// assumes reference edge times in ps from a converter on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "dld_core_defines.vh"

// Functional notes
// - loop filter is a third-order recursive filter set by four coefficients.
// - each coefficient is a fractional mantissa scaled by two to minus x.
// - first coefficient has two extra upward exponent terms for range above one.
// - lock level spans -2048 empty to +2048 full and saturates.
// - unlock below -1024, lock above +1024, otherwise hold indication.
// - fill and drain amounts are separate 8-bit programmable values.
// - per sample: fill if magnitude at or below threshold, else drain.
// - phase threshold is 16-bit unsigned picoseconds against error magnitude.
// - free-run or holdover without switchover forces phase lock indication to unlocked.
// - during switchover lock indications hold their prior value.
// - frequency detector uses same counter on period difference magnitude.
// - frequency threshold is 24-bit unsigned picoseconds.
// - 48-bit step word added to modulo 2^48 accumulator every clock.
// - 16-bit phase offset word added to accumulator output phase.
// - phase detector compares reference time with divided wraparound edge time.
module dld_core #(
    parameter FB_W = 30
) (
    input  wire              clk_in,
    input  wire              rstn_in,
    input  wire [15:0]       reg_addr_in,
    input  wire [7:0]        reg_wdata_in,
    input  wire              reg_wr_in,
    output reg  [7:0]        reg_rdata_out,
    input  wire [1:0]        loop_mode_in,
    input  wire              switchover_in,
    input  wire              ref_edge_in,
    input  wire [31:0]       ref_time_in,
    input  wire [FB_W-1:0]   fb_div_in,
    input  wire [47:0]       freq_step_word_in,
    input  wire [15:0]       alpha_mant_in,
    input  wire [4:0]        alpha_exp_in,
    input  wire [3:0]        alpha_up1_in,
    input  wire [3:0]        alpha_up2_in,
    input  wire [15:0]       beta_mant_in,
    input  wire [4:0]        beta_exp_in,
    input  wire [15:0]       gamma_mant_in,
    input  wire [4:0]        gamma_exp_in,
    input  wire [15:0]       delta_mant_in,
    input  wire [4:0]        delta_exp_in,
    input  wire [15:0]       phase_thresh_in,
    input  wire [7:0]        phase_fill_in,
    input  wire [7:0]        phase_drain_in,
    input  wire [23:0]       freq_thresh_in,
    input  wire [7:0]        freq_fill_in,
    input  wire [7:0]        freq_drain_in,
    output reg  [15:0]       phase_out,
    output reg               wrap_out,
    output reg  [47:0]       tuning_word_out,
    output wire              phase_locked_out,
    output wire              freq_locked_out,
    output wire [12:0]       phase_level_out,
    output wire [12:0]       freq_level_out
);

    // ==============================================================
    // helpers
    function [31:0] dld_abs;
        input [31:0] v;
        begin
            dld_abs = v[31] ? (~v + 32'h00000001) : v;
        end
    endfunction

    function signed [47:0] dld_scale;
        input signed [47:0] v;
        input [15:0]        m;
        input [4:0]         nx;
        input [4:0]         px;
        reg signed [64:0]   p;
        begin
            p = v * $signed({1'b0, m});
            p = p >>> (`DLD_MANT_FRAC_BITS + {2'h0, nx});
            p = p <<< px;
            dld_scale = p[47:0];
        end
    endfunction

    // ==============================================================
    // register port
    reg  [15:0] phase_ofs_r;

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase_ofs_r   <= `DLD_PHASE_OFS_RESET;
            reg_rdata_out <= 8'h00;
        end else begin
            if (reg_wr_in && reg_addr_in == `DLD_ADDR_PHASE_OFS_LO) begin
                phase_ofs_r[7:0] <= reg_wdata_in;
            end
            if (reg_wr_in && reg_addr_in == `DLD_ADDR_PHASE_OFS_HI) begin
                phase_ofs_r[15:8] <= reg_wdata_in;
            end
            case (reg_addr_in)
                `DLD_ADDR_PHASE_OFS_LO: reg_rdata_out <= phase_ofs_r[7:0];
                `DLD_ADDR_PHASE_OFS_HI: reg_rdata_out <= phase_ofs_r[15:8];
                default:                reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ==============================================================
    // phase accumulator and feedback divider
    reg  [47:0]     acc_r;
    reg  [31:0]     time_r;
    reg  [FB_W-1:0] fb_cnt_r;
    reg  [31:0]     fb_time_r;
    reg  [31:0]     fb_prev_r;
    wire [48:0]     acc_sum;
    wire            fb_event;

    assign acc_sum  = {1'b0, acc_r} + {1'b0, tuning_word_out};
    assign fb_event = acc_sum[48] && (fb_cnt_r == fb_div_in);

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_r     <= 48'h000000000000;
            time_r    <= 32'h00000000;
            fb_cnt_r  <= {FB_W{1'b0}};
            fb_time_r <= 32'h00000000;
            fb_prev_r <= 32'h00000000;
            wrap_out  <= 1'b0;
            phase_out <= 16'h0000;
        end else begin
            acc_r     <= acc_sum[47:0];
            wrap_out  <= acc_sum[48];
            phase_out <= acc_r[`DLD_PHASE_MSB:`DLD_PHASE_LSB] + phase_ofs_r;
            time_r    <= time_r + `DLD_CLK_PERIOD_PS;
            if (acc_sum[48]) begin
                fb_cnt_r <= fb_event ? {FB_W{1'b0}} : fb_cnt_r + {{(FB_W-1){1'b0}}, 1'b1};
            end
            if (fb_event) begin
                fb_prev_r <= fb_time_r;
                fb_time_r <= time_r;
            end
        end
    end

    // ==============================================================
    // phase detector and period deviation
    reg  [31:0] ref_prev_r;
    wire [31:0] phase_err;
    wire [31:0] period_dev;

    assign phase_err  = ref_time_in - fb_time_r;
    assign period_dev = (ref_time_in - ref_prev_r) - (fb_time_r - fb_prev_r);

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ref_prev_r <= 32'h00000000;
        end else if (ref_edge_in) begin
            ref_prev_r <= ref_time_in;
        end
    end

    // ==============================================================
    // third order loop filter
    reg  signed [47:0] integ_r;
    reg  signed [47:0] lp1_r;
    reg  signed [47:0] lp2_r;
    wire signed [47:0] err48;
    wire signed [47:0] integ_nxt;
    wire signed [47:0] prop_y;
    wire signed [47:0] lp1_nxt;
    wire signed [47:0] lp2_nxt;
    wire               closed;
    wire               filt_run;

    assign closed    = (loop_mode_in == `DLD_MODE_CLOSED);
    assign filt_run  = ref_edge_in && closed && !switchover_in;
    assign err48     = {{16{phase_err[31]}}, phase_err};
    assign integ_nxt = integ_r + dld_scale(err48, beta_mant_in, beta_exp_in, 5'h00);
    assign prop_y    = integ_nxt + dld_scale(err48, alpha_mant_in, alpha_exp_in,
                       {1'b0, alpha_up1_in} + {1'b0, alpha_up2_in});
    assign lp1_nxt   = lp1_r + dld_scale(prop_y - lp1_r, gamma_mant_in, gamma_exp_in, 5'h00);
    assign lp2_nxt   = lp2_r + dld_scale(lp1_nxt - lp2_r, delta_mant_in, delta_exp_in, 5'h00);

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            integ_r         <= 48'sh000000000000;
            lp1_r           <= 48'sh000000000000;
            lp2_r           <= 48'sh000000000000;
            tuning_word_out <= 48'h000000000000;
        end else begin
            if (filt_run) begin
                integ_r <= integ_nxt;
                lp1_r   <= lp1_nxt;
                lp2_r   <= lp2_nxt;
            end
            // free run uses the step word alone; holdover keeps the last correction
            if (loop_mode_in == `DLD_MODE_FREERUN) begin
                tuning_word_out <= freq_step_word_in;
            end else begin
                tuning_word_out <= freq_step_word_in + lp2_r;
            end
        end
    end

    // ==============================================================
    // lock detectors
    wire open_loop;

    assign open_loop = (loop_mode_in == `DLD_MODE_FREERUN) ||
                       (loop_mode_in == `DLD_MODE_HOLDOVER);

    dld_lock_level #(
        .MAG_W (32),
        .TH_W  (16)
    ) u_phase_lock (
        .clk_in          (clk_in),
        .rstn_in         (rstn_in),
        .sample_in       (ref_edge_in),
        .mag_in          (dld_abs(phase_err)),
        .thresh_in       (phase_thresh_in),
        .fill_in         (phase_fill_in),
        .drain_in        (phase_drain_in),
        .force_unlock_in (open_loop),
        .hold_in         (switchover_in),
        .locked_out      (phase_locked_out),
        .level_out       (phase_level_out)
    );

    dld_lock_level #(
        .MAG_W (32),
        .TH_W  (24)
    ) u_freq_lock (
        .clk_in          (clk_in),
        .rstn_in         (rstn_in),
        .sample_in       (ref_edge_in),
        .mag_in          (dld_abs(period_dev)),
        .thresh_in       (freq_thresh_in),
        .fill_in         (freq_fill_in),
        .drain_in        (freq_drain_in),
        .force_unlock_in (1'b0),
        .hold_in         (switchover_in),
        .locked_out      (freq_locked_out),
        .level_out       (freq_level_out)
    );

endmodule
`default_nettype wire

// ==== logic/dld_lock_level.v ====
// saturating fill/drain level counter with hysteresis marks
// assumes sample strobes come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "dld_core_defines.vh"

module dld_lock_level #(
    parameter MAG_W = 32,
    parameter TH_W  = 16
) (
    input  wire              clk_in,
    input  wire              rstn_in,
    input  wire              sample_in,
    input  wire [MAG_W-1:0]  mag_in,
    input  wire [TH_W-1:0]   thresh_in,
    input  wire [7:0]        fill_in,
    input  wire [7:0]        drain_in,
    input  wire              force_unlock_in,
    input  wire              hold_in,
    output reg               locked_out,
    output reg  [12:0]       level_out
);

    // ==============================================================
    // next level
    wire               hit;
    wire signed [13:0] step;
    wire signed [13:0] sum;
    reg  signed [12:0] level_nxt;
    reg                locked_nxt;

    assign hit  = (mag_in <= thresh_in);
    assign step = hit ? $signed({6'h00, fill_in}) : -$signed({6'h00, drain_in});
    assign sum  = $signed({level_out[12], level_out}) + step;

    always @* begin
        if (sum < `DLD_SUM_SAT_LO) begin
            level_nxt = `DLD_LEVEL_EMPTY;
        end else if (sum > `DLD_SUM_SAT_HI) begin
            level_nxt = `DLD_LEVEL_FULL;
        end else begin
            level_nxt = sum[12:0];
        end
    end

    always @* begin
        if (hold_in) begin
            locked_nxt = locked_out;
        end else if (force_unlock_in) begin
            locked_nxt = 1'b0;
        end else if ($signed(level_out) > `DLD_LEVEL_HIGH_MARK) begin
            locked_nxt = 1'b1;
        end else if ($signed(level_out) < `DLD_LEVEL_LOW_MARK) begin
            locked_nxt = 1'b0;
        end else begin
            locked_nxt = locked_out;
        end
    end

    // ==============================================================
    // state
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_out  <= `DLD_LEVEL_EMPTY;
            locked_out <= 1'b0;
        end else begin
            if (force_unlock_in && !hold_in) begin
                level_out <= `DLD_LEVEL_EMPTY;
            end else if (sample_in) begin
                level_out <= level_nxt;
            end
            locked_out <= locked_nxt;
        end
    end

endmodule
`default_nettype wire

// ==== testbench/dld_core_sva.sv ====
// lock indication and register port checks for the dpll core
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "dld_core_defines.vh"

module dld_core_sva (
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [1:0]  loop_mode_in,
    input wire logic        switchover_in,
    input wire logic        ref_edge_in,
    input wire logic [47:0] freq_step_word_in,
    input wire logic [47:0] tuning_word_out,
    input wire logic        phase_locked_out,
    input wire logic        freq_locked_out,
    input wire logic [12:0] phase_level_out,
    input wire logic [12:0] freq_level_out
);
    wire signed [12:0] pl = phase_level_out;
    wire signed [12:0] fl = freq_level_out;
    wire opn = loop_mode_in == `DLD_MODE_FREERUN || loop_mode_in == `DLD_MODE_HOLDOVER;
    wire sw = switchover_in;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    chk_lock_rise: assert property (pl > 1024 && !sw && !opn |=> phase_locked_out)
        else $error("phase lock late");
    chk_unlock_fall: assert property (pl < -1024 && !sw |=> !phase_locked_out)
        else $error("phase unlock late");
    chk_lock_hold: assert property (pl >= -1024 && pl <= 1024 && !sw && !opn
        |=> $stable(phase_locked_out)) else $error("lock moved between marks");
    chk_force_unlock: assert property (opn && !sw
        |=> !phase_locked_out && phase_level_out == `DLD_LEVEL_EMPTY) else $error("not forced");
    chk_switch_hold: assert property (sw
        |=> $stable(phase_locked_out) && $stable(freq_locked_out)) else $error("lock moved");
    chk_freq_lock: assert property (fl > 1024 && !sw |=> freq_locked_out)
        else $error("freq lock late");
    chk_idle_levels: assert property (!ref_edge_in && !opn
        |=> $stable(phase_level_out) && $stable(freq_level_out)) else $error("level moved");
    chk_free_run_word: assert property (loop_mode_in == `DLD_MODE_FREERUN
        |=> tuning_word_out == $past(freq_step_word_in)) else $error("step word not used");
    chk_unmapped_read: assert property (reg_addr_in != `DLD_ADDR_PHASE_OFS_LO
        && reg_addr_in != `DLD_ADDR_PHASE_OFS_HI |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind dld_core dld_core_sva u_sva (.clk_in, .rstn_in, .reg_addr_in, .reg_rdata_out,
    .loop_mode_in, .switchover_in, .ref_edge_in, .freq_step_word_in, .tuning_word_out,
    .phase_locked_out, .freq_locked_out, .phase_level_out, .freq_level_out);
`default_nettype wire

// ==== testbench/dld_ref_model.sv ====
// reference edge source standing in for the converter and detector feed
// assumes fire and time are driven by the bench just after a rising edge
`timescale 1ns/100ps
`default_nettype none

module dld_ref_model (
    input  wire logic        clk_in,
    input  wire logic        fire_in,
    input  wire logic [31:0] time_in,
    output logic             ref_edge_out,
    output logic [31:0]      ref_time_out
);
    logic [31:0] last_r = 32'h0;
    always_ff @(posedge clk_in) if (fire_in) last_r <= time_in;
    // outside a sample the time bus never repeats the stale value
    assign ref_edge_out = fire_in;
    assign ref_time_out = fire_in ? time_in : ~last_r;
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the dpll lock detect and phase accumulator core
// assumes the core, its checker and the reference model are compiled alongside
`timescale 1ns/100ps
`default_nettype none
`include "dld_core_defines.vh"

module tb_top;
    logic clk_in = 1'b0, rstn_in = 1'b0, wr = 1'b0, sw = 1'b0, fire = 1'b0;
    logic [15:0] addr = 16'h0, cm = 16'h0, pth = 16'h0064, p;
    logic [7:0]  wdata = 8'h0, pfill = 8'hc8, pdrain = 8'hff, ffill = 8'h64, fdrain = 8'h28;
    logic [1:0]  mode = `DLD_MODE_CLOSED;
    logic [4:0]  ce = 5'h0;
    logic [23:0] fth = 24'h0000c8;
    logic [31:0] tref = 32'h0, ref_time;
    logic [47:0] step = 48'h0, tw;
    logic [7:0]  rdata;
    logic [15:0] phase;
    logic [12:0] plev, flev;
    logic        ref_edge, wrap, plk, flk;
    int n_fail = 0, n_compared = 0, pe = -2048, fe = -2048, prev = 0, cyc = 0, nw, c0;
    bit pk = 1'b0, fk = 1'b0;

    initial begin
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;

    dld_ref_model u_ref (.clk_in, .fire_in(fire), .time_in(tref), .ref_edge_out(ref_edge),
        .ref_time_out(ref_time));
    dld_core dut (.clk_in, .rstn_in, .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rdata_out(rdata), .loop_mode_in(mode), .switchover_in(sw),
        .ref_edge_in(ref_edge), .ref_time_in(ref_time), .fb_div_in(30'h0),
        .freq_step_word_in(step), .alpha_mant_in(cm), .alpha_exp_in(ce),
        .alpha_up1_in(ce[3:0]), .alpha_up2_in(ce[3:0]), .beta_mant_in(cm), .beta_exp_in(ce),
        .gamma_mant_in(cm), .gamma_exp_in(ce), .delta_mant_in(cm), .delta_exp_in(ce),
        .phase_thresh_in(pth), .phase_fill_in(pfill), .phase_drain_in(pdrain),
        .freq_thresh_in(fth), .freq_fill_in(ffill), .freq_drain_in(fdrain),
        .phase_out(phase), .wrap_out(wrap), .tuning_word_out(tw), .phase_locked_out(plk),
        .freq_locked_out(flk), .phase_level_out(plev), .freq_level_out(flev));

    // ==============================================================
    // checking and bus tasks
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic int lv(input int l, input bit f, input int a, input int d);
        int n;
        n = f ? l + a : l - d;
        return n > 2048 ? 2048 : (n < -2048 ? -2048 : n);
    endfunction

    function automatic bit lk(input bit k, input int l);
        return l > 1024 ? 1'b1 : (l < -1024 ? 1'b0 : k);
    endfunction

    // one reference sample, then level and lock expectations
    task automatic sample(input int t);
        int d;
        @(posedge clk_in) #1;
        fire = 1'b1;
        tref = t;
        @(posedge clk_in) #1;
        fire = 1'b0;
        d = t - prev;
        prev = t;
        pe = (mode != `DLD_MODE_CLOSED && !sw) ? -2048 : lv(pe, (t < 0 ? -t : t) <= pth, pfill, pdrain);
        fe = lv(fe, (d < 0 ? -d : d) <= fth, ffill, fdrain);
        chk(plev, pe[12:0]);
        chk(flev, fe[12:0]);
        @(posedge clk_in) #1;
        pk = (mode != `DLD_MODE_CLOSED && !sw) ? 1'b0 : (sw ? pk : lk(pk, pe));
        fk = sw ? fk : lk(fk, fe);
        chk(plk, pk);
        chk(flk, fk);
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in) #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk_in) #1;
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_in) #1;
        addr = a;
        @(posedge clk_in) #1;
        chk(rdata, e);
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #60000;
        n_fail++;
        finish_test;
    end

    // ==============================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        chk({plev, flev, plk, flk}, {13'h1800, 13'h1800, 2'h0});
        rd_reg(`DLD_ADDR_PHASE_OFS_LO, 8'h00);
        repeat (25) sample(100);
        repeat (17) sample(-101);
        repeat (16) sample(100);
        sw = 1'b1;
        mode = `DLD_MODE_HOLDOVER;
        repeat (9) sample(-101);
        sw = 1'b0;
        sample(100);
        mode = `DLD_MODE_FREERUN;
        step = 48'h4000_0000_0001;
        repeat (3) @(posedge clk_in);
        #1 chk(tw, step);
        nw = 0;
        p = phase;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in) #1;
            p = p + 16'h4000;
            chk(phase, p);
            nw += wrap;
        end
        chk(nw, 2);
        c0 = cyc;
        p = phase;
        wr_reg(`DLD_ADDR_PHASE_OFS_LO, 8'h34);
        wr_reg(`DLD_ADDR_PHASE_OFS_HI, 8'h12);
        wr_reg(16'h030f, 8'hff);
        rd_reg(`DLD_ADDR_PHASE_OFS_LO, 8'h34);
        rd_reg(`DLD_ADDR_PHASE_OFS_HI, 8'h12);
        rd_reg(16'h030f, 8'h00);
        p = p + 16'h1234 + 16'(cyc - c0) * 16'h4000;
        chk(phase, p);
        mode = `DLD_MODE_CLOSED;
        cm = 16'h8000;
        repeat (6) begin
            @(posedge clk_in) #1;
            fire = 1'b1;
            tref = 32'h0000_03e8;
            @(posedge clk_in) #1;
            fire = 1'b0;
        end
        repeat (4) @(posedge clk_in);
        #1 chk(tw != step && !$isunknown(tw), 1'b1);
        finish_test;
    end
endmodule
`default_nettype wire
